// ---- common/mvp_defs.svh ----
/*
 * constants of the measured-value post-processing block: register
 * offsets, field positions, reset values and timing counts.
 * assumes a 25 MHz pclk; included by its bare name.
 */
// What this block does
// - moving mean, power-of-two window up to 1024
// - window takes newest, drops oldest value
// - recursive mean (x+(N-1)*prev)/N, N to 32768
// - median of last 3/5/7/9 values
// - chosen mean recomputed every measuring cycle
// - one result per incoming value
// - invalid value without hold gives error
// - hold repeats last valid 1..1024 times
// - hold count zero repeats forever
// - stats cycle 2..32768 powers or all
// - minimum, maximum, peak-to-peak made readable
// - clear command restarts cycle, drops stats
// - pass every n-th value, n 1..1000
// - decimation per selected interface only
// - trigger gates output, sync input triggers
// - no triggering outputs continuously by default
// - level mode outputs while level active
// - edge mode outputs programmed value count
// - software start, command ends early
// - count 0 ends, 16383 continuous
// - leader drives sync output for followers
`ifndef MVP_DEFS_SVH
`define MVP_DEFS_SVH
// ==========================================================
// register byte offsets
`define MVP_REG_CTRL 8'h00
`define MVP_REG_RECN 8'h04
`define MVP_REG_HOLD 8'h08
`define MVP_REG_DECIM 8'h0c
`define MVP_REG_TCNT 8'h10
`define MVP_REG_CMD 8'h14
`define MVP_REG_SMIN 8'h18
`define MVP_REG_SMAX 8'h1c
`define MVP_REG_SP2P 8'h20
`define MVP_REG_STAT 8'h24
// ==========================================================
// command bits
`define MVP_CMD_SCLR 0
`define MVP_CMD_TSTART 1
`define MVP_CMD_TSTOP 2
// ==========================================================
// reset values and limits
`define MVP_CTRL_RST 32'h0000_0000
`define MVP_RECN_RST 16'h0001
`define MVP_DECIM_RST 10'h001
`define MVP_TCNT_CONT 14'h3fff
`define MVP_WIN_MAX 11'h400
`define MVP_HOLD_MAX 11'h400
// ==========================================================
// timing
`define MVP_CLK_NS 40
`define MVP_SYNC_PULSE_NS 5000
`define MVP_SYNC_CYC \
  ((`MVP_SYNC_PULSE_NS + `MVP_CLK_NS - 1) / `MVP_CLK_NS)
`endif

// ---- common/mvp_pkg.sv ----
/*
 * types of the measured-value post-processing block.
 * assumes no other file; it uses none of the header constants.
 */
package mvp_pkg;
  // ========================================================
  // averaging selection
  typedef enum logic [1:0] {
    MVP_AVG_NONE = 2'b00,
    MVP_AVG_MOV = 2'b01,
    MVP_AVG_REC = 2'b10,
    MVP_AVG_MED = 2'b11
  } mvp_avg_t;
  // output gating selection
  typedef enum logic [1:0] {
    MVP_TRG_NONE = 2'b00,
    MVP_TRG_LEVEL = 2'b01,
    MVP_TRG_EDGE = 2'b10,
    MVP_TRG_SOFT = 2'b11
  } mvp_trg_t;
  // control register layout, msb first
  typedef struct packed {
    logic [12:0] rsvd;
    logic trg_pol;      // 1: high level / rising edge
    mvp_trg_t trg;
    logic leader;
    logic dec_net;
    logic dec_ser;
    logic hold_en;
    logic [3:0] stat_log; // 0: all values
    logic [3:0] mov_log;
    logic [1:0] med_sel;  // 3,5,7,9 values
    mvp_avg_t avg;
  } mvp_ctrl_t;
  // one output sample
  typedef struct packed {
    logic err;
    logic [31:0] data;
  } mvp_sample_t;
endpackage : mvp_pkg

// ---- hw/mvp_top.sv ----
/*
 * measured-value post-processing: hold-last-value, moving,
 * recursive and median averaging, min/max statistics, trigger
 * gating, decimation and sync leader/follower.
 * assumes one valid strobe per measuring cycle from logic on
 * pclk, an APB master, and an asynchronous sync pin.
 */
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "mvp_defs.svh"
module mvp_top (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // measured values in
  input wire logic in_valid,
  input wire logic in_ok,
  input wire logic [31:0] in_data,
  // serial and network outputs
  output logic ser_valid,
  output mvp_pkg::mvp_sample_t ser_sample,
  output logic net_valid,
  output mvp_pkg::mvp_sample_t net_sample,
  // synchronisation pins
  input wire logic sync_in,
  output logic sync_out,
  output logic meas_start
);
  // ========================================================
  // helper functions
  // signed mean by power-of-two shift, toward zero
  function automatic logic [31:0] shr_tz(
      input logic signed [42:0] s, input logic [3:0] sh);
    logic [42:0] m;
    m = s[42] ? 43'(-s) : 43'(s);
    m = m >> sh;
    shr_tz = s[42] ? 32'(-m) : 32'(m);
  endfunction : shr_tz
  // middle element of the first k entries of v
  function automatic logic [31:0] med_pick(
      input logic [9*32-1:0] v, input logic [3:0] k);
    logic [3:0] r;
    logic signed [31:0] a;
    logic signed [31:0] b;
    med_pick = 32'h0;
    for (int i = 0; i < 9; i++) begin
      r = 4'h0;
      a = signed'(v[i*32 +: 32]);
      for (int j = 0; j < 9; j++) begin
        b = signed'(v[j*32 +: 32]);
        if (j < int'(k) && (b < a || (b == a && j < i))) begin
          r = 4'(r + 4'h1);
        end
      end
      if (i < int'(k) && r == (k >> 1)) begin
        med_pick = v[i*32 +: 32];
      end
    end
  endfunction : med_pick
  // ========================================================
  // registers
  mvp_pkg::mvp_ctrl_t ctrl_q;   // mode and option bits
  logic [15:0] recn_q;          // recursive N
  logic [10:0] hold_q;          // hold count, 0 = forever
  logic [9:0] decim_q;          // output every n-th
  logic [13:0] tcnt_q;          // trigger value count
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic acc;                    // access phase in progress
  logic wr_done;                // write completes this edge
  logic hit;                    // address is mapped
  logic cmd_sclr;
  logic cmd_tstart;
  logic cmd_tstop;
  logic clr_win;                // averaging setup rewritten
  logic [31:0] rd_mux;
  // statistics views
  logic signed [31:0] smin_q;
  logic signed [31:0] smax_q;
  logic [14:0] scnt_q;
  logic [13:0] tleft_q;
  logic gate_q;
  assign acc = psel & penable;
  assign wr_done = acc & pready_q & pwrite & ~pslverr_q;
  always_comb begin
    hit = 1'b1;
    rd_mux = 32'h0;
    case (paddr)
      `MVP_REG_CTRL: rd_mux = ctrl_q;
      `MVP_REG_RECN: rd_mux = {16'h0, recn_q};
      `MVP_REG_HOLD: rd_mux = {21'h0, hold_q};
      `MVP_REG_DECIM: rd_mux = {22'h0, decim_q};
      `MVP_REG_TCNT: rd_mux = {18'h0, tcnt_q};
      `MVP_REG_CMD: rd_mux = 32'h0;
      `MVP_REG_SMIN: rd_mux = smin_q;
      `MVP_REG_SMAX: rd_mux = smax_q;
      `MVP_REG_SP2P: rd_mux = 32'(smax_q - smin_q);
      `MVP_REG_STAT: rd_mux = {2'h0, gate_q, tleft_q, scnt_q};
      default: hit = 1'b0;
    endcase
  end
  // apb handshake: one wait cycle, answer from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else if (ce) begin
      if (acc && !pready_q) begin
        pready_q <= 1'b1;
        pslverr_q <= ~hit;  // unmapped: error, data zero
        prdata_q <= pwrite ? 32'h0 : rd_mux;
      end else begin
        pready_q <= 1'b0;
        pslverr_q <= 1'b0;
      end
    end
  end
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;
  // command strobes live for the completing edge only
  assign cmd_sclr = wr_done && paddr == `MVP_REG_CMD
                    && pwdata[`MVP_CMD_SCLR];
  assign cmd_tstart = wr_done && paddr == `MVP_REG_CMD
                      && pwdata[`MVP_CMD_TSTART];
  assign cmd_tstop = wr_done && paddr == `MVP_REG_CMD
                     && pwdata[`MVP_CMD_TSTOP];
  assign clr_win = wr_done && paddr == `MVP_REG_CTRL;
  // configuration writes; default ctrl is no averaging and
  // no triggering, so values flow from reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `MVP_CTRL_RST;
      recn_q <= `MVP_RECN_RST;
      hold_q <= 11'h0;
      decim_q <= `MVP_DECIM_RST;
      tcnt_q <= `MVP_TCNT_CONT;
    end else if (ce && wr_done) begin
      case (paddr)
        `MVP_REG_CTRL: ctrl_q <= {13'h0, pwdata[18:0]};
        `MVP_REG_RECN: recn_q <= pwdata[15:0];
        `MVP_REG_HOLD: hold_q <= pwdata[10:0];
        `MVP_REG_DECIM: decim_q <= pwdata[9:0];
        `MVP_REG_TCNT: tcnt_q <= pwdata[13:0];
        default: ;
      endcase
    end
  end
  // ========================================================
  // sync pin: three flops, change taken when 2nd and 3rd agree
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;   // debounced sync level
  logic lvl_chg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      lvl_q <= 1'b0;
    end else if (ce) begin
      s1_q <= sync_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        lvl_q <= s3_q;
      end
    end
  end
  assign lvl_chg = (s2_q == s3_q) && (s3_q != lvl_q);
  // ========================================================
  // leader pulses sync out per measuring cycle; a follower
  // turns each rising sync edge into a measuring request
  logic [7:0] sp_q;
  logic sync_out_q;
  logic meas_start_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_q <= 8'h0;
      sync_out_q <= 1'b0;
      meas_start_q <= 1'b0;
    end else if (ce) begin
      meas_start_q <= ~ctrl_q.leader & lvl_chg & s3_q;
      if (ctrl_q.leader && in_valid) begin
        sp_q <= 8'(`MVP_SYNC_CYC);
        sync_out_q <= 1'b1;
      end else if (sp_q != 8'h0) begin
        sp_q <= 8'(sp_q - 8'h1);
        sync_out_q <= (sp_q != 8'h1);
      end else begin
        sync_out_q <= 1'b0;
      end
    end
  end
  assign sync_out = sync_out_q;
  assign meas_start = meas_start_q;
  // ========================================================
  // hold-last-value in front of the averaging
  logic [31:0] last_q;   // last valid value
  logic have_q;          // a valid value has been seen
  logic [10:0] miss_q;   // invalid values since then
  logic x_ok;
  logic signed [31:0] x;
  always_comb begin
    x = in_ok ? in_data : last_q;
    x_ok = in_ok;
    if (!in_ok && ctrl_q.hold_en && have_q) begin
      x_ok = (hold_q == 11'h0)
             || (miss_q < hold_q);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_q <= 32'h0;
      have_q <= 1'b0;
      miss_q <= 11'h0;
    end else if (ce && in_valid) begin
      if (in_ok) begin
        last_q <= in_data;
        have_q <= 1'b1;
        miss_q <= 11'h0;
      end else if (miss_q != `MVP_HOLD_MAX) begin
        miss_q <= 11'(miss_q + 11'h1);
      end
    end
  end
  // ========================================================
  // shared window store for the moving mean and the median
  logic [31:0] win_q [1024];
  logic [9:0] wp_q;
  logic [10:0] fill_q;
  logic signed [42:0] sum_q;
  logic [10:0] nwin;
  logic signed [31:0] oldv;
  logic signed [42:0] sum_d;
  logic [9*32-1:0] medv;
  assign nwin = 11'h1 << ctrl_q.mov_log;
  always_comb begin
    // oldest value leaves once the window is full
    oldv = (fill_q >= nwin) ? win_q[10'(wp_q - nwin[9:0])]
                            : 32'h0;
    sum_d = sum_q + 43'(x) - 43'(oldv);
    medv[31:0] = x;
    for (int j = 1; j < 9; j++) begin
      // slots not refilled since the last restart read as zero
      medv[j*32 +: 32] = (fill_q >= 11'(j)) ? win_q[10'(wp_q - 10'(j))]
                                             : 32'h0;
    end
  end
  // a window change restarts filling, so no stale sum stays
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_q <= 10'h0;
      fill_q <= 11'h0;
      sum_q <= 43'h0;
    end else if (ce) begin
      if (clr_win) begin
        fill_q <= 11'h0;
        sum_q <= 43'h0;
      end else if (in_valid && x_ok) begin
        wp_q <= 10'(wp_q + 10'h1);
        sum_q <= sum_d;
        if (fill_q != `MVP_WIN_MAX) begin
          fill_q <= 11'(fill_q + 11'h1);
        end
      end
    end
  end
  // storage has no reset: unread until filled
  always_ff @(posedge pclk) begin
    if (ce && in_valid && x_ok) begin
      win_q[wp_q] <= x;
    end
  end
  // ========================================================
  // recursive mean; plain divider, N is any 1..32768
  logic signed [31:0] rec_q;
  logic [15:0] rn;
  logic signed [50:0] rnum;
  logic signed [50:0] rquo;
  assign rn = (recn_q == 16'h0) ? 16'h1 : recn_q;
  always_comb begin
    rnum = 51'(x) + 51'($signed({1'b0, 16'(rn - 16'h1)}) * rec_q);
    rquo = rnum / $signed({35'h0, rn});
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rec_q <= 32'h0;
    end else if (ce) begin
      if (clr_win) begin
        rec_q <= 32'h0;
      end else if (in_valid && x_ok) begin
        rec_q <= 32'(rquo);
      end
    end
  end
  // ========================================================
  // result: one per incoming value, any mode
  mvp_pkg::mvp_sample_t res_q;
  logic res_v_q;
  logic [31:0] avg_d;
  always_comb begin
    case (ctrl_q.avg)
      mvp_pkg::MVP_AVG_MOV:
        avg_d = shr_tz(sum_d, ctrl_q.mov_log);
      mvp_pkg::MVP_AVG_REC: avg_d = 32'(rquo);
      mvp_pkg::MVP_AVG_MED:
        avg_d = med_pick(medv, 4'(4'h3 + {ctrl_q.med_sel, 1'b0}));
      default: avg_d = x;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_q <= '0;
      res_v_q <= 1'b0;
    end else if (ce) begin
      res_v_q <= in_valid;
      if (in_valid) begin
        res_q.err <= ~x_ok;
        res_q.data <= x_ok ? avg_d : 32'h0;
      end
    end
  end
  // ========================================================
  // statistics over the evaluation cycle
  logic signed [31:0] rmin_q;
  logic signed [31:0] rmax_q;
  logic signed [31:0] nmin;
  logic signed [31:0] nmax;
  logic cyc_end;
  always_comb begin
    nmin = signed'(res_q.data);
    nmax = signed'(res_q.data);
    if (scnt_q != 15'h0) begin
      if (rmin_q < nmin) nmin = rmin_q;
      if (rmax_q > nmax) nmax = rmax_q;
    end
    cyc_end = (ctrl_q.stat_log != 4'h0)
              && (15'(scnt_q + 15'h1) == (15'h1 << ctrl_q.stat_log));
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scnt_q <= 15'h0;
      rmin_q <= 32'h0;
      rmax_q <= 32'h0;
      smin_q <= 32'h0;
      smax_q <= 32'h0;
    end else if (ce) begin
      if (cmd_sclr) begin
        scnt_q <= 15'h0;
        smin_q <= 32'h0;
        smax_q <= 32'h0;
      end else if (res_v_q && !res_q.err) begin
        rmin_q <= nmin;
        rmax_q <= nmax;
        scnt_q <= cyc_end ? 15'h0 : 15'(scnt_q + 15'h1);
        // all-values mode publishes after each value
        if (cyc_end || ctrl_q.stat_log == 4'h0) begin
          smin_q <= nmin;
          smax_q <= nmax;
        end
      end
    end
  end
  // ========================================================
  // trigger gating: only output is gated, never the rate
  logic gate;
  logic edge_hit;
  logic cont;
  assign cont = (tleft_q == `MVP_TCNT_CONT);
  assign edge_hit = lvl_chg && (s3_q == ctrl_q.trg_pol);
  always_comb begin
    case (ctrl_q.trg)
      mvp_pkg::MVP_TRG_LEVEL:
        gate = (lvl_q == ctrl_q.trg_pol);
      mvp_pkg::MVP_TRG_EDGE: gate = (tleft_q != 14'h0);
      mvp_pkg::MVP_TRG_SOFT: gate = (tleft_q != 14'h0);
      default: gate = 1'b1;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tleft_q <= 14'h0;
    end else if (ce) begin
      if (ctrl_q.trg == mvp_pkg::MVP_TRG_EDGE && edge_hit) begin
        tleft_q <= tcnt_q;
      end else if (ctrl_q.trg == mvp_pkg::MVP_TRG_SOFT
                   && cmd_tstart) begin
        tleft_q <= tcnt_q;
      end else if (cmd_tstop) begin
        tleft_q <= 14'h0;
      end else if (res_v_q && gate && !cont
                   && tleft_q != 14'h0) begin
        tleft_q <= 14'(tleft_q - 14'h1);
      end
    end
  end
  // ========================================================
  // decimation counter runs on gated values only
  logic [9:0] dcnt_q;
  logic [9:0] dn;
  logic dpass;
  assign dn = (decim_q == 10'h0) ? 10'h1 : decim_q;
  assign dpass = (dcnt_q == 10'h0);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dcnt_q <= 10'h0;
    end else if (ce && res_v_q && gate) begin
      dcnt_q <= (10'(dcnt_q + 10'h1) >= dn) ? 10'h0
                : 10'(dcnt_q + 10'h1);
    end
  end
  // ========================================================
  // interface outputs, each decimated only when selected
  logic ser_v_q;
  logic net_v_q;
  mvp_pkg::mvp_sample_t ser_q;
  mvp_pkg::mvp_sample_t net_q;
  logic ser_go;   // serial interface passes this value
  logic net_go;   // network interface passes this value
  assign ser_go = res_v_q && gate && (!ctrl_q.dec_ser || dpass);
  assign net_go = res_v_q && gate && (!ctrl_q.dec_net || dpass);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ser_v_q <= 1'b0;
      net_v_q <= 1'b0;
      ser_q <= '0;
      net_q <= '0;
      gate_q <= 1'b0;
    end else if (ce) begin
      gate_q <= gate;
      ser_v_q <= ser_go;
      net_v_q <= net_go;
      // samples hold between pulses of their own interface
      if (ser_go) begin
        ser_q <= res_q;
      end
      if (net_go) begin
        net_q <= res_q;
      end
    end
  end
  assign ser_valid = ser_v_q;
  assign net_valid = net_v_q;
  assign ser_sample = ser_q;
  assign net_sample = net_q;
endmodule : mvp_top

// ---- tb/mvp_partner.sv ----
/*
 * far side of the block: sync source and output sinks.
 * assumes its tasks are called just after a pclk edge.
 */
`timescale 1ns/1ps
`include "mvp_defs.svh"
module mvp_partner (
  // clock
  input wire logic pclk,
  // device outputs
  input wire logic ser_valid,
  input wire mvp_pkg::mvp_sample_t ser_sample,
  input wire logic net_valid,
  input wire logic meas_start,
  // sync pin towards the device
  output logic sync_in
);
  // pulses seen and last serial sample
  int ser_n = 0;
  int net_n = 0;
  int ms_n = 0;
  mvp_pkg::mvp_sample_t last_s;
  initial sync_in = 1'b0;
  // sinks count each one-cycle valid
  always @(posedge pclk) begin
    if (ser_valid === 1'b1) begin
      ser_n++;
      last_s = ser_sample;
    end
    if (net_valid === 1'b1) begin
      net_n++;
    end
    if (meas_start === 1'b1) begin
      ms_n++;
    end
  end
  // one pulse; high and pause both the minimum width
  task automatic pulse();
    sync_in <= 1'b1;
    repeat (`MVP_SYNC_CYC) @(posedge pclk);
    sync_in <= 1'b0;
    repeat (`MVP_SYNC_CYC) @(posedge pclk);
  endtask : pulse
  // a level is held far longer than one cycle
  task automatic level(input logic v);
    sync_in <= v;
    repeat (8) @(posedge pclk);
  endtask : level
endmodule : mvp_partner

// ---- tb/mvp_properties.sv ----
/*
 * port assertions of the post-processing block.
 * assumes a bind onto mvp_top, one clock, async low reset.
 */
`timescale 1ns/1ps
module mvp_props (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb answer
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  // stream and sync
  input wire logic in_valid,
  input wire logic ser_valid,
  input wire mvp_pkg::mvp_sample_t ser_sample,
  input wire logic net_valid,
  input wire logic sync_out,
  input wire logic meas_start
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ==========================================================
  // helper: cycles the leader pulse has stood high so far
  logic [7:0] hi_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_q <= 8'h00;
    end else begin
      hi_q <= sync_out ? hi_q + 8'h01 : 8'h00;
    end
  end
  // ==========================================================
  // apb: one wait state, one-cycle answer
  a_ready_wait: assert property (
    psel && $rose(penable) |-> !pready ##1 pready)
    else $error("apb answer not after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_answer: assert property (pslverr |-> pready && !prdata)
    else $error("slave error without pready or with data");
  // ==========================================================
  // stream: each result two edges after a value
  a_ser_cause: assert property (
    ser_valid |-> $past(in_valid, 2))
    else $error("serial value without input");
  a_net_cause: assert property (
    net_valid |-> $past(in_valid, 2))
    else $error("network value without input");
  a_ser_single: assert property (
    ser_valid |=> !ser_valid)
    else $error("two serial values in a row");
  a_sample_hold: assert property (
    $changed(ser_sample) |-> ser_valid)
    else $error("serial sample moved without valid");
  a_err_zero: assert property (
    ser_valid && ser_sample.err |-> ser_sample.data == 32'h0)
    else $error("error sample carries data");
  // ==========================================================
  // sync: leader pulse width, follower start pulse
  a_sync_width: assert property (
    $fell(sync_out) |-> hi_q == 8'd125)
    else $error("leader pulse width wrong");
  a_start_pulse: assert property (
    meas_start |=> !meas_start)
    else $error("start pulse longer than one cycle");
  c_err: cover property (ser_valid && ser_sample.err);
  c_sync: cover property ($fell(sync_out));
  c_slverr: cover property (pslverr);
  c_start: cover property (meas_start);
endmodule : mvp_props

// ---- tb/test_measured_value_postprocessing.sv ----
/*
 * self-checking bench of the post-processing block.
 * assumes package, header, partner and checker compiled first.
 */
`timescale 1ns/1ps
`include "mvp_defs.svh"
module test_measured_value_postprocessing;
  // ==========================================================
  // signals
  logic pclk, presetn, ce, psel, penable, pwrite, pready, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, in_data;
  logic pslverr, in_valid, in_ok, ser_valid, net_valid;
  logic sync_in, sync_out, meas_start;
  mvp_pkg::mvp_sample_t ser_sample, net_sample;
  int mismatches = 0;
  int n_checks = 0;
  mvp_top uut (.*);
  mvp_partner fp (.*);
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // ==========================================================
  // end of run and comparisons
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test
  task automatic chk_w(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t word %h want %h", $time, g, e);
    end
  endtask : chk_w
  task automatic chk_s(input logic [32:0] g, input logic [32:0] e);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t sample %h want %h", $time, g, e);
    end
  endtask : chk_s
  // ==========================================================
  // bus, reset and stream drivers; all start after an edge
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // wait for the answer; only the watchdog ends a hang
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge: psel is never assigned twice at once
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk_w(rd, e);
  endtask : rdc
  task automatic rst();
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask : rst
  task automatic feed(input logic ok, input logic [31:0] d);
    in_valid <= 1'b1;
    in_ok <= ok;
    in_data <= d;
    @(posedge pclk);
    in_valid <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : feed
  task automatic fx(input logic ok, input logic [31:0] d,
    input logic [32:0] e);
    feed(ok, d);
    chk_s(fp.last_s, e);
    chk_s(net_sample, e);
  endtask : fx
  // k values in; serial and network counts expected
  task automatic burst(input int k, input int es, input int en);
    int s0, n0;
    s0 = fp.ser_n;
    n0 = fp.net_n;
    repeat (k) feed(1'b1, 32'h5);
    chk_w(fp.ser_n - s0, es);
    chk_w(fp.net_n - n0, en);
  endtask : burst
  task automatic stats(input int a, input int b, input int c);
    rdc(`MVP_REG_SMIN, a);
    rdc(`MVP_REG_SMAX, b);
    rdc(`MVP_REG_SP2P, c);
  endtask : stats
  // ==========================================================
  // scenarios
  task automatic t_reset();
    ce <= 1'b0;
    burst(1, 0, 0); // frozen: value ignored
    ce <= 1'b1;
    burst(2, 2, 2);
    fx(1'b1, 32'h1234, 33'h1234);
    rdc(`MVP_REG_RECN, 32'h1);
    rdc(`MVP_REG_DECIM, 32'h1);
    rdc(`MVP_REG_TCNT, 32'h3fff);
    rdc(8'h40, 32'h0);
    chk_w({31'h0, er}, 32'h1);
  endtask : t_reset
  task automatic t_filters();
    int s;
    wr(`MVP_REG_CTRL, 32'h3);
    fx(1'b1, 32'd5, 33'd0);
    fx(1'b1, 32'd1, 33'd1);
    fx(1'b1, 32'd9, 33'd5);
    fx(1'b1, 32'd3, 33'd3);
    wr(`MVP_REG_CTRL, 32'h21);
    s = 0;
    for (int i = 1; i <= 6; i++) begin
      s += 4 * i;
      s -= (i > 4) ? 4 * (i - 4) : 0;
      fx(1'b1, 32'(4 * i), 33'(s >> 2));
    end
    wr(`MVP_REG_RECN, 32'h2);
    wr(`MVP_REG_CTRL, 32'h2);
    fx(1'b1, 32'd0, 33'd0);
    fx(1'b1, 32'd8, 33'd4);
    fx(1'b1, 32'd8, 33'd6);
  endtask : t_filters
  task automatic t_hold();
    wr(`MVP_REG_HOLD, 32'h2);
    wr(`MVP_REG_CTRL, 32'h1000);
    fx(1'b1, 32'd7, 33'd7);
    fx(1'b0, 32'd1, 33'd7);
    fx(1'b0, 32'd1, 33'd7);
    fx(1'b0, 32'd1, 33'h1_0000_0000);
    wr(`MVP_REG_HOLD, 32'h0);
    fx(1'b1, 32'd7, 33'd7);
    repeat (3) fx(1'b0, 32'd1, 33'd7);
    wr(`MVP_REG_CTRL, 32'h0);
    fx(1'b0, 32'd1, 33'h1_0000_0000);
  endtask : t_hold
  task automatic t_stats();
    wr(`MVP_REG_CMD, 32'h1);
    feed(1'b1, 32'd3);
    feed(1'b1, 32'd9);
    feed(1'b1, 32'd1);
    stats(1, 9, 8);
    wr(`MVP_REG_CMD, 32'h1);
    feed(1'b1, 32'd5);
    stats(5, 5, 0);
    wr(`MVP_REG_CTRL, 32'h100);
    wr(`MVP_REG_CMD, 32'h1);
    feed(1'b1, 32'd4);
    feed(1'b1, 32'd6);
    feed(1'b1, 32'd20);
    stats(4, 6, 2);
  endtask : t_stats
  task automatic t_gate();
    wr(`MVP_REG_DECIM, 32'h3);
    wr(`MVP_REG_CTRL, 32'h2000);
    burst(6, 2, 6);
    wr(`MVP_REG_CTRL, 32'h4000);
    burst(6, 6, 2);
    wr(`MVP_REG_DECIM, 32'h1);
    wr(`MVP_REG_TCNT, 32'h2);
    wr(`MVP_REG_CTRL, 32'h30000);
    wr(`MVP_REG_CMD, 32'h2);
    burst(4, 2, 2);
    wr(`MVP_REG_TCNT, 32'h3fff);
    wr(`MVP_REG_CMD, 32'h2);
    burst(3, 3, 3);
    wr(`MVP_REG_CMD, 32'h4);
    burst(2, 0, 0);
    wr(`MVP_REG_TCNT, 32'h0);
    wr(`MVP_REG_CMD, 32'h2);
    burst(2, 0, 0);
    wr(`MVP_REG_TCNT, 32'h3);
    for (int p = 1; p >= 0; p--) begin
      wr(`MVP_REG_CTRL, 32'h20000 | (p << 18));
      burst(1, 0, 0);
      fp.pulse();
      burst(5, 3, 3);
    end
    wr(`MVP_REG_CTRL, 32'h50000);
    burst(2, 0, 0);
    fp.level(1'b1);
    burst(2, 2, 2);
    fp.level(1'b0);
    burst(2, 0, 0);
    wr(`MVP_REG_CTRL, 32'h10000);
    burst(2, 2, 2);
  endtask : t_gate
  task automatic t_sync();
    int m0;
    wr(`MVP_REG_CTRL, 32'h0);
    m0 = fp.ms_n;
    // as a sync source, rising edges stay 0.5 ms apart
    repeat (12500) @(posedge pclk);
    fp.pulse();
    chk_w(fp.ms_n - m0, 32'h1);
    wr(`MVP_REG_CTRL, 32'h8000);
    feed(1'b1, 32'd5);
    repeat (130) @(posedge pclk);
  endtask : t_sync
  // ==========================================================
  // main sequence and watchdog
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {in_valid, in_ok, in_data} = '0;
    ce = 1'b1;
    rst();
    t_reset();
    rst();
    t_filters();
    t_hold();
    t_stats();
    t_gate();
    t_sync();
    finish_test();
  end
  initial begin
    #2000000;
    $display("[ERR] %0t watchdog expired", $time);
    mismatches++;
    finish_test();
  end
endmodule : test_measured_value_postprocessing
bind mvp_top mvp_props u_props (.*);
